// [design/msc_device.sv]
`timescale 1ns/1ns
module msc_device
  import msc_pkg::*;
#(
  parameter longint unsigned INIT_CYC = msc_pkg::MSC_INIT_MAX_CYC,
  parameter int unsigned RESET_MIN_CYC = msc_pkg::MSC_RESET_MIN_CYC,
  parameter int unsigned INT_OFF_CYC = 2
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  msc_sideband_if.device side,
  input wire logic fault_event,
  input wire logic flag_clear,
  input wire logic settings_wr,
  input wire logic settings_wdata,
  output logic bus_enable,
  output logic low_power_active,
  output logic settings_value,
  output logic monitor_data_pending,
  output logic [7:0] status_byte,
  output logic init_done
);
  import msc_pkg::*;

  typedef enum logic [2:0] {
    MSC_ST_INIT = 3'b001,
    MSC_ST_RUN  = 3'b010,
    MSC_ST_HOLD = 3'b100
  } msc_state_e;

  initial begin
    if (INIT_CYC < 1) $error("msc_device: INIT_CYC must be at least 1");
    if (INIT_CYC > MSC_INIT_MAX_CYC)
      $error("msc_device: INIT_CYC beyond the 2000 ms limit");
    if (RESET_MIN_CYC > MSC_RESET_MIN_CYC)
      $error("msc_device: RESET_MIN_CYC beyond the 2 us threshold");
    if (RESET_MIN_CYC < 1) $error("msc_device: RESET_MIN_CYC must be at least 1");
    if (INT_OFF_CYC < 1 || INT_OFF_CYC > MSC_INT_OFF_MAX_CYC)
      $error("msc_device: INT_OFF_CYC out of range");
  end

  logic sel_n_s;
  logic rst_n_s;
  logic lp_s;
  logic [2:0] pins_s;

  // pull-up defaults: select and reset idle high so an open pin deselects
  msc_sync #(.WIDTH(3), .RESET_VAL(3'b011)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({side.low_power_request, side.module_reset_n, side.module_select_n}),
    .sync_out(pins_s)
  );
  assign sel_n_s = pins_s[0];
  assign rst_n_s = pins_s[1];
  assign lp_s = pins_s[2];

  msc_state_e state_reg, state_next;
  logic [63:0] init_cnt_reg, init_cnt_next;
  logic [31:0] low_cnt_reg, low_cnt_next;
  logic qualified_reg, qualified_next;
  logic pending_reg, pending_next;
  logic int_flag_reg, int_flag_next;
  logic [31:0] off_cnt_reg, off_cnt_next;
  logic int_drive_reg, int_drive_next;
  logic settings_reg, settings_next;

  wire in_init = (state_reg == MSC_ST_INIT);
  wire in_run = (state_reg == MSC_ST_RUN);
  wire reset_low = ~rst_n_s;
  wire low_long = low_cnt_reg >= RESET_MIN_CYC;
  wire init_expired = init_cnt_reg == INIT_CYC - 64'd1;
  wire completion_evt = in_init && init_expired;
  // faults only flagged once running; init and hold report nothing stale
  wire fault_set = fault_event && in_run;
  wire set_evt = completion_evt || fault_set;
  wire flag_fell = int_flag_reg && !int_flag_next;
  wire off_done = !int_flag_reg && (off_cnt_reg >= INT_OFF_CYC);
  wire drive_on = int_flag_next && !pending_next;
  wire hold_next = (state_next == MSC_ST_HOLD);
  // counter parks at zero after the release so it cannot wrap and re-fire
  wire [31:0] off_cnt_kept = (off_cnt_next > INT_OFF_CYC) ? 32'd0 : off_cnt_next;

  always_comb begin
    low_cnt_next = reset_low ? (low_long ? low_cnt_reg : low_cnt_reg + 32'd1) : 32'd0;
    qualified_next = reset_low && (qualified_reg || low_long);
    state_next = state_reg;
    init_cnt_next = init_cnt_reg;
    pending_next = pending_reg;
    settings_next = settings_reg;
    case (state_reg)
      MSC_ST_INIT: begin
        init_cnt_next = init_cnt_reg + 64'd1;
        if (init_expired) begin
          state_next = MSC_ST_RUN;
          pending_next = 1'b0;
        end
      end
      MSC_ST_RUN: begin
        if (qualified_reg) begin
          state_next = MSC_ST_HOLD;
        end
        if (settings_wr) begin
          settings_next = settings_wdata;
        end
      end
      MSC_ST_HOLD: begin
        // data pending again so the host distrusts status until completion
        pending_next = 1'b1;
        settings_next = MSC_SETTINGS_DEFAULT;
        init_cnt_next = 64'd0;
        if (!reset_low) begin
          state_next = MSC_ST_INIT;
        end
      end
      default: begin
        state_next = MSC_ST_INIT;
      end
    endcase
    // short pulses never reach hold, so settings survive
    if (reset_low && !qualified_reg && in_run) begin
      state_next = MSC_ST_RUN;
    end
    // set wins over a same-cycle clear
    int_flag_next = set_evt ? 1'b1 : (flag_clear ? 1'b0 : int_flag_reg);
    if (flag_fell) begin
      off_cnt_next = 32'd1;
    end else begin
      off_cnt_next = (off_cnt_reg != 32'd0) ? off_cnt_reg + 32'd1 : 32'd0;
    end
    int_drive_next = int_drive_reg;
    if (drive_on) begin
      int_drive_next = 1'b1;
    end else if (off_done) begin
      int_drive_next = 1'b0;
    end
    if (hold_next) begin
      int_drive_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= MSC_ST_INIT;
      init_cnt_reg <= 64'd0;
      low_cnt_reg <= 32'd0;
      qualified_reg <= 1'b0;
      pending_reg <= MSC_STATUS_BYTE_RESET[MSC_DATA_PENDING_BIT];
      int_flag_reg <= 1'b0;
      off_cnt_reg <= 32'd0;
      int_drive_reg <= 1'b0;
      settings_reg <= MSC_SETTINGS_DEFAULT;
    end else begin
      state_reg <= state_next;
      init_cnt_reg <= init_cnt_next;
      low_cnt_reg <= low_cnt_next;
      qualified_reg <= qualified_next;
      pending_reg <= pending_next;
      int_flag_reg <= int_flag_next;
      off_cnt_reg <= off_cnt_kept;
      int_drive_reg <= int_drive_next;
      settings_reg <= settings_next;
    end
  end

  logic bus_en_reg;
  logic lp_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_en_reg <= 1'b0;
      lp_reg <= 1'b0;
    end else begin
      bus_en_reg <= ~sel_n_s;
      lp_reg <= lp_s;
    end
  end

  assign bus_enable = bus_en_reg;
  assign low_power_active = lp_reg;
  assign settings_value = settings_reg;
  assign monitor_data_pending = pending_reg;
  assign status_byte = {7'h00, pending_reg};
  assign init_done = in_run;

  assign side.presence_n = 1'b0;
  // open drain: level is always low, only the enable moves
  assign side.interrupt_n_o = 1'b0;
  assign side.interrupt_n_oe = int_drive_reg;
endmodule : msc_device

// [design/msc_host.sv]
`timescale 1ns/1ns
module msc_host
  import msc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  msc_sideband_if.host side,
  input wire logic select_req,
  input wire logic reset_req,
  input wire logic low_power_req,
  output logic module_present,
  output logic interrupt_seen,
  output logic status_valid
);
  import msc_pkg::*;
  logic [1:0] in_s;
  logic sel_reg;
  logic rst_reg;
  logic lp_reg;
  logic int_reg;

  msc_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({side.interrupt_n, side.presence_n}),
    .sync_out(in_s)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg <= 1'b0;
      rst_reg <= 1'b0;
      lp_reg <= 1'b0;
      int_reg <= 1'b0;
    end else begin
      sel_reg <= select_req;
      rst_reg <= reset_req;
      lp_reg <= low_power_req;
      int_reg <= ~in_s[1];
    end
  end

  assign side.module_select_n = ~sel_reg;
  assign side.module_reset_n = ~rst_reg;
  assign side.low_power_request = lp_reg;
  assign module_present = ~in_s[0];
  assign interrupt_seen = int_reg;
  // status trusted while any interrupt (completion or fault) is seen and no reset is requested
  assign status_valid = int_reg && !rst_reg;
endmodule : msc_host

// [design/msc_pkg.sv]
package msc_pkg;
  localparam int unsigned MSC_CLK_HZ = 100_000_000;
  localparam int unsigned MSC_CLK_PERIOD_NS = 10;
  // minimum low time on the reset pin, in ns
  localparam int unsigned MSC_RESET_MIN_NS = 2_000;
  localparam int unsigned MSC_RESET_MIN_CYC =
    (MSC_RESET_MIN_NS + MSC_CLK_PERIOD_NS - 1) / MSC_CLK_PERIOD_NS;
  // longest time from reset release to fully functional, in ms
  localparam int unsigned MSC_INIT_MAX_MS = 2_000;
  localparam longint unsigned MSC_INIT_MAX_CYC =
    longint'(MSC_INIT_MAX_MS) * (MSC_CLK_HZ / 1000);
  // longest time from flag clear to interrupt release, in us
  localparam int unsigned MSC_INT_OFF_MAX_US = 500;
  localparam int unsigned MSC_INT_OFF_MAX_CYC = MSC_INT_OFF_MAX_US * (MSC_CLK_HZ / 1_000_000);
  // management byte holding the monitor-data-pending flag
  localparam logic [7:0] MSC_STATUS_BYTE_ADDR = 8'h02;
  localparam int unsigned MSC_DATA_PENDING_BIT = 0;
  localparam logic [7:0] MSC_STATUS_BYTE_RESET = 8'h01;
  localparam logic MSC_SETTINGS_DEFAULT = 1'b0;
endpackage : msc_pkg

// [design/msc_sideband_if.sv]
`timescale 1ns/1ns
interface msc_sideband_if;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_request;
  logic presence_n;
  logic interrupt_n_o;
  logic interrupt_n_oe;
  // open drain wire with host pull-up
  wire interrupt_n = interrupt_n_oe ? interrupt_n_o : 1'b1;
  modport device (
    input module_select_n,
    input module_reset_n,
    input low_power_request,
    output presence_n,
    output interrupt_n_o,
    output interrupt_n_oe
  );
  modport host (
    output module_select_n,
    output module_reset_n,
    output low_power_request,
    input presence_n,
    input interrupt_n
  );
endinterface : msc_sideband_if

// [design/msc_sync.sv]
`timescale 1ns/1ns
module msc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  initial begin
    if (WIDTH < 1) $error("msc_sync: WIDTH must be at least 1");
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : msc_sync

// [sim/msc_sideband_props.sv]
`timescale 1ns/1ns
module msc_sideband_props #(
  parameter int INIT_CYC = 40,
  parameter int RESET_MIN_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic module_reset_n,
  input wire logic presence_n,
  input wire logic interrupt_n_o,
  input wire logic interrupt_n_oe,
  input wire interrupt_n
);
  localparam int INIT_HI = INIT_CYC + 8;
  logic [15:0] low_cnt_reg;
  // margins cover the pin synchroniser delay on both edges
  wire long_low = low_cnt_reg >= 16'(RESET_MIN_CYC + 2);
  wire short_low = (low_cnt_reg != 16'h0) && (low_cnt_reg <= 16'(RESET_MIN_CYC - 3));
  logic rst_pin_d_reg;
  wire pin_rose = module_reset_n && !rst_pin_d_reg;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) rst_pin_d_reg <= 1'b1;
    else rst_pin_d_reg <= module_reset_n;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) low_cnt_reg <= 16'h0;
    else if (module_reset_n) low_cnt_reg <= 16'h0;
    else if (low_cnt_reg != 16'hFFFF) low_cnt_reg <= low_cnt_reg + 16'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_presence; presence_n == 1'b0; endproperty
  property p_drive_low; interrupt_n_oe |-> interrupt_n_o == 1'b0; endproperty
  property p_wire; interrupt_n == !interrupt_n_oe; endproperty
  property p_reset_hold; low_cnt_reg > 16'(RESET_MIN_CYC + 5) |-> !interrupt_n_oe; endproperty
  property p_init_wait; pin_rose && long_low |-> !interrupt_n_oe [*8]; endproperty
  property p_init_done; pin_rose && long_low |-> ##[1:INIT_HI] interrupt_n_oe; endproperty
  property p_short; pin_rose && short_low && interrupt_n_oe |-> interrupt_n_oe [*8]; endproperty
  property p_powerup; $rose(reset_n) |-> ##[1:INIT_HI] interrupt_n_oe; endproperty
  a_presence: assert property (p_presence) else $error("presence not low");
  a_drive_low: assert property (p_drive_low) else $error("interrupt driven high");
  a_wire: assert property (p_wire) else $error("interrupt wire level wrong");
  a_reset_hold: assert property (p_reset_hold) else $error("held reset kept irq");
  a_init_wait: assert property (p_init_wait) else $error("irq too early");
  a_init_done: assert property (p_init_done) else $error("no completion irq");
  a_short: assert property (p_short) else $error("short pulse acted");
  a_powerup: assert property (p_powerup) else $error("no power-up irq");
  c_long: cover property (pin_rose && long_low);
  c_short: cover property (pin_rose && short_low && interrupt_n_oe);
  c_release: cover property ($fell(interrupt_n_oe));
endmodule : msc_sideband_props

// [sim/tb_module_sideband_control.sv]
`timescale 1ns/1ns
module tb_module_sideband_control;
  import msc_pkg::*;
  localparam int INIT_CYC = 40;
  localparam int RESET_MIN_CYC = 10;
  logic clk_sys, reset_n, sel, rst, lp, fault, clr, swr, swd;
  logic bus_en, lp_act, set_val, pend, done, present, seen, valid;
  logic [7:0] stat;
  int n_fail = 0;
  int checks_done = 0;
  msc_sideband_if msc_sideband_if_i ();
  msc_device #(.INIT_CYC(64'(INIT_CYC)), .RESET_MIN_CYC(RESET_MIN_CYC), .INT_OFF_CYC(2))
    msc_device_i (.clk_sys(clk_sys), .reset_n(reset_n), .side(msc_sideband_if_i),
    .fault_event(fault), .flag_clear(clr), .settings_wr(swr), .settings_wdata(swd),
    .bus_enable(bus_en), .low_power_active(lp_act), .settings_value(set_val),
    .monitor_data_pending(pend), .status_byte(stat), .init_done(done));
  msc_host msc_host_i (.clk_sys(clk_sys), .reset_n(reset_n), .side(msc_sideband_if_i),
    .select_req(sel), .reset_req(rst), .low_power_req(lp), .module_present(present),
    .interrupt_seen(seen), .status_valid(valid));
  msc_sideband_props #(.INIT_CYC(INIT_CYC), .RESET_MIN_CYC(RESET_MIN_CYC))
    msc_sideband_props_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .module_reset_n(msc_sideband_if_i.module_reset_n),
    .presence_n(msc_sideband_if_i.presence_n),
    .interrupt_n_o(msc_sideband_if_i.interrupt_n_o),
    .interrupt_n_oe(msc_sideband_if_i.interrupt_n_oe),
    .interrupt_n(msc_sideband_if_i.interrupt_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // bounded wait on the resolved open-drain wire
  task wait_int(input logic lvl, input int lim);
    int k;
    k = 0;
    while (msc_sideband_if_i.interrupt_n !== lvl && k < lim) begin
      tick(1);
      k++;
    end
    check(msc_sideband_if_i.interrupt_n, lvl);
    if (k >= lim) give_verdict();
  endtask : wait_int
  initial begin
    {reset_n, sel, rst, lp, fault, clr, swr, swd} = '0;
    tick(3);
    reset_n = 1'b1;
    check(msc_sideband_if_i.module_select_n, 1'b1);
    wait_int(1'b0, INIT_CYC + 20);
    check(pend, 1'b0);
    check(stat, 8'h00);
    check(done, 1'b1);
    check(present, 1'b1);
    swd = 1'b1;
    swr = 1'b1;
    tick(1);
    swr = 1'b0;
    tick(1);
    check(set_val, 1'b1);
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(12);
    check(set_val, 1'b1);
    check(msc_sideband_if_i.interrupt_n, 1'b0);
    check(seen, 1'b1);
    check(valid, 1'b1);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    wait_int(1'b1, 6);
    fault = 1'b1;
    tick(1);
    fault = 1'b0;
    wait_int(1'b0, 10);
    sel = 1'b1;
    tick(5);
    check(bus_en, 1'b1);
    sel = 1'b0;
    tick(5);
    check(bus_en, 1'b0);
    lp = 1'b1;
    tick(5);
    check(lp_act, 1'b1);
    lp = 1'b0;
    tick(5);
    check(lp_act, 1'b0);
    rst = 1'b1;
    tick(RESET_MIN_CYC + 10);
    check(set_val, 1'b0);
    check(stat, 8'h01);
    check(valid, 1'b0);
    check(msc_sideband_if_i.interrupt_n, 1'b1);
    rst = 1'b0;
    tick(5);
    check(msc_sideband_if_i.interrupt_n, 1'b1);
    wait_int(1'b0, INIT_CYC + 20);
    check(pend, 1'b0);
    give_verdict();
  end
endmodule : tb_module_sideband_control
